// ==== hdl/ats_device.sv ====
// sequence-A trigger select and channel launch, device end of the link
`timescale 1ns/1ps
module ats_device (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   ats_link_if.dev link,
   input wire logic conv_done_in,
   output logic conv_start_out,
   output logic [3:0] conv_channel_out,
   output logic seq_busy_out,
   output logic [1:0] ch0_source_out,
   output logic temp_sensor_sel_out
);
   // register state
   logic [1:0] src_reg;
   logic [1:0] src_next;
   logic [11:0] mask_reg;
   logic [11:0] mask_next;
   logic [5:0] trig_reg;
   logic [5:0] trig_next;
   logic pol_reg;
   logic pol_next;
   logic skip_reg;
   logic skip_next;
   logic ena_reg;
   logic ena_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic sw_start;
   // trigger path
   logic raw_trig;
   logic synced_trig;
   logic cond_trig;
   logic prev_reg;
   logic prev_next;
   logic hw_edge;
   logic launch;
   // sequencer state
   ats_pkg::ats_seq_t state_reg;
   ats_pkg::ats_seq_t state_next;
   logic [3:0] chan_reg;
   logic [3:0] chan_next;
   logic start_reg;
   logic start_next;
   logic [4:0] first_hit;
   logic [4:0] next_hit;

   // lowest set mask bit at or above from_ch; msb of result says found
   function automatic logic [4:0] find_from(input logic [11:0] mask,
                                            input logic [3:0] from_ch);
      logic found;
      logic [3:0] idx;
      found = 1'b0;
      idx = 4'h0;
      for (int i = 0; i < ats_pkg::NUM_CH; i++)
      begin
         if (!found && (i >= int'(from_ch)) && mask[i])
         begin
            found = 1'b1;
            idx = 4'(i);
         end
      end
      return {found, idx};
   endfunction

   // a write is taken once, on the first cycle of a held request
   wire logic take = link.reg_req && !ack_reg;
   wire logic wr_ctrl = take && link.reg_wr &&
                        (link.reg_addr == ats_pkg::ADDR_SEQUENCE_A_CONTROL);
   wire logic wr_src = take && link.reg_wr &&
                       (link.reg_addr == ats_pkg::ADDR_CH0_SRC);

   // register writes and reads; reserved bits are not stored and read zero
   always_comb
   begin
      src_next = src_reg;
      mask_next = mask_reg;
      trig_next = trig_reg;
      pol_next = pol_reg;
      skip_next = skip_reg;
      ena_next = ena_reg;
      rdata_next = rdata_reg;
      ack_next = take;
      sw_start = 1'b0;
      if (wr_src)
      begin
         src_next = link.reg_wdata[ats_pkg::SRC_LSB +: ats_pkg::SRC_W];
      end
      if (wr_ctrl)
      begin
         // mask, trigger and enable may change together in one write
         mask_next = link.reg_wdata[ats_pkg::CH_LSB +: ats_pkg::NUM_CH];
         trig_next = link.reg_wdata[ats_pkg::TRIG_LSB +: ats_pkg::TRIG_W];
         pol_next = link.reg_wdata[ats_pkg::POL_BIT];
         skip_next = link.reg_wdata[ats_pkg::SKIP_BIT];
         ena_next = link.reg_wdata[ats_pkg::ENA_BIT];
         sw_start = link.reg_wdata[ats_pkg::START_BIT];
      end
      if (take && !link.reg_wr)
      begin
         rdata_next = 32'h0000_0000;
         if (link.reg_addr == ats_pkg::ADDR_CH0_SRC)
         begin
            rdata_next[ats_pkg::SRC_LSB +: ats_pkg::SRC_W] = src_reg;
         end
         else if (link.reg_addr == ats_pkg::ADDR_SEQUENCE_A_CONTROL)
         begin
            // start is never stored, so it always reads back zero
            rdata_next[ats_pkg::CH_LSB +: ats_pkg::NUM_CH] = mask_reg;
            rdata_next[ats_pkg::TRIG_LSB +: ats_pkg::TRIG_W] = trig_reg;
            rdata_next[ats_pkg::POL_BIT] = pol_reg;
            rdata_next[ats_pkg::SKIP_BIT] = skip_reg;
            rdata_next[ats_pkg::ENA_BIT] = ena_reg;
         end
      end
      if (!rstn_in)
      begin
         src_next = ats_pkg::CH0_SRC_RESET[ats_pkg::SRC_LSB +: ats_pkg::SRC_W];
         mask_next = ats_pkg::CH_RESET;
         trig_next = ats_pkg::TRIG_RESET;
         pol_next = 1'b0;
         skip_next = 1'b0;
         ena_next = 1'b0;
         rdata_next = 32'h0000_0000;
         ack_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      src_reg <= src_next;
      mask_reg <= mask_next;
      trig_reg <= trig_next;
      pol_reg <= pol_next;
      skip_reg <= skip_next;
      ena_reg <= ena_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
   end

   // only the numbered trigger input can launch the sequence from hardware
   assign raw_trig = link.hw_trig[trig_reg];

   ats_sync3 ats_sync3_i (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .async_in(raw_trig),
      .sync_out(synced_trig)
   );

   // skipping the stages saves latency but needs a clean, held pulse
   assign cond_trig = skip_reg ? raw_trig : synced_trig;

   // edge detect on the conditioned trigger, one pulse per transition in the direction pol_reg selects
   always_comb
   begin
      prev_next = rstn_in ? cond_trig : 1'b0;
   end

   always_ff @(posedge sys_clk_in)
   begin
      prev_reg <= prev_next;
   end

   assign hw_edge = pol_reg ? (cond_trig && !prev_reg)
                            : (!cond_trig && prev_reg);
   // a start in the same write that sets enable still launches
   assign launch = ena_next && (sw_start || (ena_reg && hw_edge));

   assign first_hit = find_from(mask_next, 4'h0);
   assign next_hit = find_from(mask_reg, chan_reg + 4'h1);

   // sequencer walks the mask; launches during a pass are dropped
   always_comb
   begin
      state_next = state_reg;
      chan_next = chan_reg;
      start_next = 1'b0;
      case (state_reg)
         ats_pkg::SEQ_IDLE:
         begin
            if (launch && first_hit[4])
            begin
               chan_next = first_hit[3:0];
               start_next = 1'b1;
               state_next = ats_pkg::SEQ_WAIT;
            end
         end
         ats_pkg::SEQ_WAIT:
         begin
            if (conv_done_in)
            begin
               if (next_hit[4])
               begin
                  chan_next = next_hit[3:0];
                  start_next = 1'b1;
               end
               else
               begin
                  state_next = ats_pkg::SEQ_IDLE;
               end
            end
         end
         default:
         begin
            state_next = ats_pkg::SEQ_IDLE;
         end
      endcase
      if (!rstn_in)
      begin
         state_next = ats_pkg::SEQ_IDLE;
         chan_next = 4'h0;
         start_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      start_reg <= start_next;
   end

   assign link.reg_ack = ack_reg;
   assign link.reg_rdata = rdata_reg;
   assign conv_start_out = start_reg;
   assign conv_channel_out = chan_reg;
   assign seq_busy_out = (state_reg == ats_pkg::SEQ_WAIT);
   assign ch0_source_out = src_reg;
   assign temp_sensor_sel_out = (src_reg == ats_pkg::SRC_TEMP_SENSOR);
endmodule // ats_device

// ==== shared/ats_pkg.sv ====
// constants shared by the trigger-select front end, its link and the host
package ats_pkg;
   // device register offsets, as seen on the link
   localparam logic [7:0] ADDR_CH0_SRC = 8'h04;
   localparam logic [7:0] ADDR_SEQUENCE_A_CONTROL = 8'h08;
   localparam logic [31:0] CH0_SRC_RESET = 32'h0000_0000;
   // channel-0 source select field
   localparam int SRC_LSB = 0;
   localparam int SRC_W = 2;
   localparam logic [1:0] SRC_ANALOG_PIN_ZERO = 2'h0;
   localparam logic [1:0] SRC_TEMP_SENSOR = 2'h3;
   // sequence-A control fields
   localparam int NUM_CH = 12;
   localparam int CH_LSB = 0;
   localparam int TRIG_LSB = 12;
   localparam int TRIG_W = 6;
   localparam int NUM_TRIG = 64;
   localparam int POL_BIT = 18;
   localparam int SKIP_BIT = 19;
   localparam int START_BIT = 26;
   localparam int ENA_BIT = 31;
   localparam logic [11:0] CH_RESET = 12'h000;
   localparam logic [5:0] TRIG_RESET = 6'h00;
   // host-side APB register offsets
   localparam logic [7:0] HOST_CMD = 8'h00;
   localparam logic [7:0] HOST_WDATA = 8'h04;
   localparam logic [7:0] HOST_RDATA = 8'h08;
   localparam logic [7:0] HOST_STATUS = 8'h0C;
   localparam logic [7:0] HOST_TRIG_LO = 8'h10;
   localparam logic [7:0] HOST_TRIG_HI = 8'h14;
   // host command word fields
   localparam int CMD_WRITE_BIT = 8;
   localparam int CMD_GO_BIT = 9;
   // sequencer and host transfer states
   typedef enum logic [0:0] {SEQ_IDLE, SEQ_WAIT} ats_seq_t;
   typedef enum logic [0:0] {HST_IDLE, HST_REQ} ats_hst_t;
endpackage

// ==== shared/ats_link_if.sv ====
// register link and hardware trigger lines between host and device
`timescale 1ns/1ps
interface ats_link_if;
   logic reg_req;
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_ack;
   logic [31:0] reg_rdata;
   logic [ats_pkg::NUM_TRIG-1:0] hw_trig;

   modport dev (
      input reg_req,
      input reg_wr,
      input reg_addr,
      input reg_wdata,
      input hw_trig,
      output reg_ack,
      output reg_rdata
   );

   modport host (
      output reg_req,
      output reg_wr,
      output reg_addr,
      output reg_wdata,
      output hw_trig,
      input reg_ack,
      input reg_rdata
   );
endinterface // ats_link_if

// ==== hdl/ats_sync3.sv ====
// three-stage trigger synchroniser with agreement filter
`timescale 1ns/1ps
module ats_sync3 (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic async_in,
   output logic sync_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic out_reg;
   logic out_next;

   // first stage feeds only the second; output moves once stages 2 and 3 agree
   always_comb
   begin
      stage_next = {stage_reg[1:0], async_in};
      out_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : out_reg;
      if (!rstn_in)
      begin
         stage_next = 3'h0;
         out_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      stage_reg <= stage_next;
      out_reg <= out_next;
   end

   assign sync_out = out_reg;
endmodule // ats_sync3

// ==== hdl/ats_host.sv ====
// host end: APB slave that drives the register link and trigger lines
`timescale 1ns/1ps
module ats_host (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   ats_link_if.host link
);
   ats_pkg::ats_hst_t state_reg;
   ats_pkg::ats_hst_t state_next;
   logic [7:0] addr_reg;
   logic [7:0] addr_next;
   logic wr_reg;
   logic wr_next;
   logic [31:0] wdata_reg;
   logic [31:0] wdata_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [63:0] trig_reg;
   logic [63:0] trig_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic mapped;

   wire logic setup = psel_in && !penable_in;
   wire logic apb_wr = psel_in && penable_in && pwrite_in;

   // decode for the error answer; read data has its own case
   always_comb
   begin
      case (paddr_in)
         ats_pkg::HOST_CMD, ats_pkg::HOST_WDATA, ats_pkg::HOST_RDATA,
         ats_pkg::HOST_STATUS, ats_pkg::HOST_TRIG_LO,
         ats_pkg::HOST_TRIG_HI: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // APB writes, link transfer and read data captured at setup
   always_comb
   begin
      state_next = state_reg;
      addr_next = addr_reg;
      wr_next = wr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      trig_next = trig_reg;
      prdata_next = prdata_reg;
      if (setup)
      begin
         case (paddr_in)
            ats_pkg::HOST_CMD: prdata_next = {23'h00_0000, wr_reg, addr_reg};
            ats_pkg::HOST_WDATA: prdata_next = wdata_reg;
            ats_pkg::HOST_RDATA: prdata_next = rdata_reg;
            ats_pkg::HOST_STATUS:
               prdata_next = {31'h0000_0000, state_reg == ats_pkg::HST_REQ};
            ats_pkg::HOST_TRIG_LO: prdata_next = trig_reg[31:0];
            ats_pkg::HOST_TRIG_HI: prdata_next = trig_reg[63:32];
            default: prdata_next = 32'h0000_0000;
         endcase
      end
      case (state_reg)
         ats_pkg::HST_IDLE:
         begin
            // commands are ignored while a transfer is in flight
            if (apb_wr && (paddr_in == ats_pkg::HOST_CMD))
            begin
               addr_next = pwdata_in[7:0];
               wr_next = pwdata_in[ats_pkg::CMD_WRITE_BIT];
               if (pwdata_in[ats_pkg::CMD_GO_BIT])
               begin
                  state_next = ats_pkg::HST_REQ;
               end
            end
            if (apb_wr && (paddr_in == ats_pkg::HOST_WDATA))
            begin
               wdata_next = pwdata_in;
            end
         end
         ats_pkg::HST_REQ:
         begin
            if (link.reg_ack)
            begin
               if (!wr_reg)
               begin
                  rdata_next = link.reg_rdata;
               end
               state_next = ats_pkg::HST_IDLE;
            end
         end
         default:
         begin
            state_next = ats_pkg::HST_IDLE;
         end
      endcase
      // trigger lines come from registers on this clock, so skip is safe
      if (apb_wr && (paddr_in == ats_pkg::HOST_TRIG_LO))
      begin
         trig_next[31:0] = pwdata_in;
      end
      if (apb_wr && (paddr_in == ats_pkg::HOST_TRIG_HI))
      begin
         trig_next[63:32] = pwdata_in;
      end
      if (!rstn_in)
      begin
         state_next = ats_pkg::HST_IDLE;
         addr_next = 8'h00;
         wr_next = 1'b0;
         wdata_next = 32'h0000_0000;
         rdata_next = 32'h0000_0000;
         trig_next = 64'h0000_0000_0000_0000;
         prdata_next = 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      trig_reg <= trig_next;
      prdata_reg <= prdata_next;
   end

   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign prdata_out = prdata_reg;
   assign link.reg_req = (state_reg == ats_pkg::HST_REQ);
   assign link.reg_wr = wr_reg;
   assign link.reg_addr = addr_reg;
   assign link.reg_wdata = wdata_reg;
   assign link.hw_trig = trig_reg;
endmodule // ats_host

// ==== sim/ats_monitor.sv ====
// concurrent checks on the register link and the launch outputs
`timescale 1ns/1ps
module ats_monitor (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic reg_req,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic reg_ack,
   input wire logic [31:0] reg_rdata,
   input wire logic conv_done_in,
   input wire logic conv_start_out,
   input wire logic [3:0] conv_channel_out,
   input wire logic seq_busy_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);

   // a request is taken on the first edge it is seen unanswered
   sequence link_take;
      reg_req && !reg_ack;
   endsequence
   // answer to a read of the control word
   sequence ctrl_read_done;
      reg_ack && !$past(reg_wr) &&
         ($past(reg_addr) == ats_pkg::ADDR_SEQUENCE_A_CONTROL);
   endsequence

   ack_latency_a: assert property (link_take |=> reg_ack)
      else $error("link answer not one cycle after request");
   ack_pulse_a: assert property (reg_ack |=> !reg_ack)
      else $error("link answer longer than one cycle");
   ack_cause_a: assert property (
      reg_ack |-> $past(reg_req) && !$past(reg_ack))
      else $error("link answer without request");
   start_reads_zero_a: assert property (
      ctrl_read_done |-> reg_rdata[ats_pkg::START_BIT] == 1'b0)
      else $error("start bit read back as one");
   launch_pulse_a: assert property (conv_start_out |=> !conv_start_out)
      else $error("launch pulse longer than one cycle");
   launch_busy_a: assert property (conv_start_out |-> seq_busy_out)
      else $error("launch while sequence not busy");
   step_next_a: assert property (
      conv_done_in && seq_busy_out |=> conv_start_out || !seq_busy_out)
      else $error("no step after conversion done");
   step_upward_a: assert property (
      conv_start_out && $past(conv_done_in)
         |-> conv_channel_out > $past(conv_channel_out))
      else $error("channel order not ascending");
endmodule // ats_monitor

// ==== sim/ats_tb.sv ====
// self-checking bench: APB host end driving the device end over the link
`timescale 1ns/1ps
module ats_tb;
   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic perr;
   logic conv_done_in = 1'b0;
   logic conv_start_out;
   logic [3:0] conv_channel_out;
   logic seq_busy_out;
   logic [1:0] ch0_source_out;
   logic temp_sensor_sel_out;
   int bad_count = 0;
   int samples_checked = 0;
   int seed = 94284;
   int cycles = 0;
   int conv_wait = 0;
   logic [3:0] exp_q[$];

   ats_link_if link ();
   ats_host ats_host_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .link(link));
   ats_device ats_device_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .link(link), .conv_done_in(conv_done_in),
      .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
      .seq_busy_out(seq_busy_out), .ch0_source_out(ch0_source_out),
      .temp_sensor_sel_out(temp_sensor_sel_out));
   ats_monitor ats_monitor_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .reg_req(link.reg_req), .reg_wr(link.reg_wr),
      .reg_addr(link.reg_addr), .reg_ack(link.reg_ack),
      .reg_rdata(link.reg_rdata), .conv_done_in(conv_done_in),
      .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
      .seq_busy_out(seq_busy_out));

   always #5 sys_clk_in = ~sys_clk_in;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one APB transfer; held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      q = prdata_out;
      perr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // device register access through the host command registers
   task automatic dev(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      logic [31:0] s;
      if (wr) apb(1'b1, ats_pkg::HOST_WDATA, d, s);
      apb(1'b1, ats_pkg::HOST_CMD, {22'h0, 1'b1, wr, a}, s);
      s = 32'h0000_0001;
      for (int i = 0; i < 50 && s[0] !== 1'b0; i++)
         apb(1'b0, ats_pkg::HOST_STATUS, 32'h0000_0000, s);
      apb(1'b0, ats_pkg::HOST_RDATA, 32'h0000_0000, q);
   endtask

   // only the half holding line t is written, so one write moves it
   task automatic set_lines(input logic [63:0] v, input logic [5:0] t);
      logic [31:0] s;
      if (t[5]) apb(1'b1, ats_pkg::HOST_TRIG_HI, v[63:32], s);
      else apb(1'b1, ats_pkg::HOST_TRIG_LO, v[31:0], s);
   endtask

   task automatic expect_mask(input logic [11:0] m);
      for (int c = 0; c < 12; c++)
         if (m[c]) exp_q.push_back(c[3:0]);
   endtask

   task automatic settle();
      repeat (3) @(posedge sys_clk_in);
      for (int i = 0; i < 200 && seq_busy_out !== 1'b0; i++)
         @(posedge sys_clk_in);
      chk("busy after pass", 32'h0000_0000, seq_busy_out);
      chk("pending channels", 32'h0000_0000, exp_q.size());
   endtask

   // converter stand-in; every launch is matched against the oldest note
   // each signal gets one assignment per edge, done pulses for one cycle
   always @(posedge sys_clk_in)
   begin
      conv_done_in <= (conv_wait == 1);
      if (conv_start_out === 1'b1)
      begin
         conv_wait <= 1 + ($unsigned($random(seed)) % 3);
         if (exp_q.size() == 0) chk("stray launch", 0, 1);
         else chk("channel", exp_q.pop_front(), conv_channel_out);
      end
      else if (conv_wait > 0)
      begin
         conv_wait <= conv_wait - 1;
      end
   end

   // hang guard
   always @(posedge sys_clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   initial
   begin
      logic [31:0] q;
      logic [11:0] m;
      logic [5:0] t;
      logic [63:0] idle;
      logic [63:0] act;
      logic pol;
      logic skip;
      int n;
      repeat (20) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      dev(1'b0, ats_pkg::ADDR_CH0_SRC, 32'h0000_0000, q);
      chk("source reset", ats_pkg::CH0_SRC_RESET, q);
      dev(1'b0, ats_pkg::ADDR_SEQUENCE_A_CONTROL, 32'h0000_0000, q);
      chk("mask reset", ats_pkg::CH_RESET, q[11:0]);
      dev(1'b0, 8'h0C, 32'h0000_0000, q);
      chk("unmapped link read", 32'h0000_0000, q);
      apb(1'b0, 8'h18, 32'h0000_0000, q);
      chk("slave error", 32'h0000_0001, perr);
      // every source code, reserved ones pass through raw
      for (int c = 0; c < 4; c++)
      begin
         dev(1'b1, ats_pkg::ADDR_CH0_SRC, c, q);
         chk("source out", c, ch0_source_out);
         chk("temp select", c == 3, temp_sensor_sel_out);
         dev(1'b0, ats_pkg::ADDR_CH0_SRC, 32'h0000_0000, q);
         chk("source read", c, q[1:0]);
      end
      // software start: single top channel, full mask, empty mask, random
      for (int k = 0; k < 6; k++)
      begin
         m = (k == 0) ? 12'h800 : (k == 1) ? 12'hFFF : 12'($random(seed));
         if (k == 2) m = 12'h000;
         expect_mask(m);
         dev(1'b1, ats_pkg::ADDR_SEQUENCE_A_CONTROL, {1'b1, 4'h0, 1'b1, 14'h0, m}, q);
         settle();
         dev(1'b0, ats_pkg::ADDR_SEQUENCE_A_CONTROL, 32'h0000_0000, q);
         chk("start read", 32'h0000_0000, q[26]);
         chk("mask read", m, q[11:0]);
         dev(1'b1, ats_pkg::ADDR_SEQUENCE_A_CONTROL, {20'h0_0000, m}, q);
      end
      // hardware launch for both polarities and synchroniser settings
      for (int k = 0; k < 4; k++)
      begin
         pol = k[0];
         skip = k[1];
         t = 6'($random(seed));
         m = 12'($random(seed)) | 12'h001;
         act = 64'h1 << t;
         idle = pol ? 64'h0 : act;
         if (pol) act = 64'h1 << t;
         else act = 64'h0;
         set_lines(idle, t);
         set_lines(act, t);
         set_lines(idle, t);
         dev(1'b1, ats_pkg::ADDR_SEQUENCE_A_CONTROL,
            {1'b1, 11'h000, skip, pol, t, m}, q);
         set_lines(idle | (64'h1 << (t ^ 6'h01)), t);
         set_lines(idle, t);
         expect_mask(m);
         set_lines(act, t);
         n = 0;
         do
         begin
            @(posedge sys_clk_in);
            #1;
            n++;
         end
         while (conv_start_out !== 1'b1 && n < 20);
         // skip: edge seen and start registered on the first edge after
         // the line moves; stages add three edges plus the agreement flop
         chk("launch delay", skip ? 1 : 5, n);
         settle();
         set_lines(idle, t);
         settle();
         dev(1'b1, ats_pkg::ADDR_SEQUENCE_A_CONTROL,
            {1'b0, 11'h000, skip, pol, t, m}, q);
      end
      print_verdict();
   end
endmodule // ats_tb
